/* File: hw/crc_pkg.sv */
// Purpose: Shared constants and types for the core regulator control bank
// Assumes: APB slave, 32-bit data, 12-bit byte address
// Notes: Analog side is reached through packed structs
//
// Notes on behaviour
// - Enable and float bits pick three modes
// - Reset leaves regulator in normal mode
// - Float bit1 resets 0, enable bit0 resets 1
// - Level code bits 7:4, reset 0xb
// - Codes 0-5 lowest, then 50mV steps
// - Normal mode regulates at selected level
// - Float mode disables and floats output
// - Shutdown disables and pulls output down
// - Shutdown with brownout on and core fed by regulator requests chip reset
// - Shutdown without brownout latches until power cycle
// - Regulation good flag bit 12, read only
// - Good flag has 90/87 percent hysteresis
// - Raising level drops flag until reached
// - Good flag low in float mode
// - Current limit leaves output unregulated
// - Decode offsets 0x0, 0x4, 0x8, 0x10, 0x14, 0x18
// - Brownout threshold bits 7:4, reset 0x9
// - Brownout enable bit0, reset 1
package crc_pkg;

    // ---------------------------------------------
    // Register map
    // ---------------------------------------------
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_BOD = 12'h004;
    localparam logic [11:0] ADDR_RST = 12'h008;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h010;
    localparam logic [11:0] ADDR_IRQ_EN = 12'h014;
    localparam logic [11:0] ADDR_IRQ_CLR = 12'h018;

    // ---------------------------------------------
    // Field positions and reset values
    // ---------------------------------------------
    localparam int EN_BIT = 0;
    localparam int FLOAT_BIT = 1;
    localparam int CODE_LSB = 4;
    localparam int GOOD_BIT = 12;
    localparam logic EN_RST = 1'h1;
    localparam logic FLOAT_RST = 1'h0;
    localparam logic [3:0] CODE_RST = 4'hb;
    localparam logic [3:0] BOD_THR_RST = 4'h9;
    localparam logic BOD_EN_RST = 1'h1;

    // Level code mapping, millivolts
    localparam logic [3:0] CODE_FLOOR = 4'h5;
    localparam logic [10:0] MV_FLOOR = 11'h320;
    localparam logic [10:0] MV_STEP = 11'h032;
    // Target at the reset level code, nominal core voltage
    localparam logic [10:0] MV_RST = 11'h44c;

    // Cycles the good flag is held low after a raise
    localparam logic [2:0] RAISE_BLANK = 3'h4;

    // Interrupt event bits
    localparam int N_EV = 4;
    localparam int EV_GOOD_RISE = 0;
    localparam int EV_GOOD_FALL = 1;
    localparam int EV_CLIMIT = 2;
    localparam int EV_RST_REQ = 3;

    // ---------------------------------------------
    // Types
    // ---------------------------------------------
    typedef enum logic [1:0] {
        CRC_NORMAL = 2'b00,
        CRC_FLOAT = 2'b01,
        CRC_SHUT = 2'b10
    } crc_mode_t;

    // Asynchronous indications from the analog side
    typedef struct packed {
        logic supply_ok;      // Input supply present
        logic core_on_reg;    // Core supply fed by regulator
        logic above_assert;   // Output above upper threshold
        logic above_deassert; // Output above lower threshold
        logic current_limit;  // Load current limit active
    } crc_ana_in_t;

    // Controls toward the analog side
    typedef struct packed {
        logic enable;          // Regulator powered
        logic float_out;       // Output floated
        logic pull_down;       // Output pulled to 0V
        logic [3:0] level_code;
        logic [10:0] level_mv; // Target voltage in mV
        logic bod_enable;
        logic [3:0] bod_threshold;
    } crc_ana_out_t;

    // Target millivolts for a level code
    function automatic logic [10:0] level_mv(input logic [3:0] code);
        logic [3:0] steps;
        steps = (code > CODE_FLOOR) ? code - CODE_FLOOR : 4'h0;
        level_mv = MV_FLOOR + 11'(MV_STEP * steps);
    endfunction

endpackage

/* File: hw/crc_regs.sv */
// Purpose: Register bank and mode control for the core regulator
// Assumes: Single clock, asynchronous active-low reset
// Notes: Zero-wait APB; read data registered in the setup cycle
`timescale 1ns/100ps
module crc_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire crc_pkg::crc_ana_in_t ana_in,
    output crc_pkg::crc_ana_out_t ana_out,
    output logic chip_reset_req,
    output logic irq
);

    // ---------------------------------------------
    // Bus decode
    // ---------------------------------------------
    logic setup_ph;   // First cycle of a transfer
    logic access_ph;  // Completing cycle of a transfer
    logic wr_en;      // Write takes effect
    logic hit;        // Address is mapped

    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    assign wr_en = access_ph & pwrite;
    // Zero wait states: every access completes at once
    assign pready = 1'b1;

    always_comb begin
        case (paddr)
            crc_pkg::ADDR_CTRL,
            crc_pkg::ADDR_BOD,
            crc_pkg::ADDR_RST,
            crc_pkg::ADDR_IRQ_STAT,
            crc_pkg::ADDR_IRQ_EN,
            crc_pkg::ADDR_IRQ_CLR: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Unmapped addresses answer with an error
    assign pslverr = access_ph & ~hit;

    // ---------------------------------------------
    // Input synchronisers
    // ---------------------------------------------
    localparam int NIN = $bits(crc_pkg::crc_ana_in_t);
    logic [NIN-1:0] s1_ff;   // Metastability catcher, read by s2 only
    logic [NIN-1:0] s2_ff;
    logic [NIN-1:0] s3_ff;
    logic [NIN-1:0] filt_ff; // Accepted once s2 and s3 agree
    crc_pkg::crc_ana_in_t in_q;
    logic supply_prev_ff;    // Last supply level, edge detect

    // Three stages, change counted when last two agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            filt_ff <= '0;
            supply_prev_ff <= 1'b0;
        end else begin
            s1_ff <= ana_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            filt_ff <= (s2_ff & s3_ff) | (filt_ff & (s2_ff ^ s3_ff));
            supply_prev_ff <= in_q.supply_ok;
        end
    end

    assign in_q = filt_ff;

    // ---------------------------------------------
    // Control registers
    // ---------------------------------------------
    logic en_ff;           // Regulator enable
    logic float_ff;        // Float-output select
    logic [3:0] code_ff;   // Level select code
    logic bod_en_ff;       // Brownout detect enable
    logic [3:0] bod_thr_ff;
    logic shut_lock_ff;    // Shutdown held until power cycle
    logic rst_req_ff;      // Chip reset request
    logic ctrl_wr;
    logic bod_wr;
    logic nxt_en;
    logic supply_lost;
    logic shut_req;        // Write asks for shutdown

    assign ctrl_wr = wr_en & (paddr == crc_pkg::ADDR_CTRL) & pstrb[0];
    assign bod_wr = wr_en & (paddr == crc_pkg::ADDR_BOD) & pstrb[0];
    assign supply_lost = supply_prev_ff & ~in_q.supply_ok;
    assign nxt_en = pwdata[crc_pkg::EN_BIT];
    assign shut_req = ctrl_wr & ~nxt_en;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_ff <= crc_pkg::EN_RST;
            float_ff <= crc_pkg::FLOAT_RST;
        end else if (supply_lost) begin
            // Power cycle of the input supply restarts
            en_ff <= crc_pkg::EN_RST;
            float_ff <= crc_pkg::FLOAT_RST;
        end else if (ctrl_wr && !shut_lock_ff && !rst_req_ff) begin
            if (!(shut_req && in_q.core_on_reg && bod_en_ff)) begin
                en_ff <= nxt_en;
            end
            float_ff <= pwdata[crc_pkg::FLOAT_BIT];
        end
    end

    // level code, written as a whole nibble
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            code_ff <= crc_pkg::CODE_RST;
        end else if (ctrl_wr) begin
            code_ff <= pwdata[crc_pkg::CODE_LSB +: 4];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bod_en_ff <= crc_pkg::BOD_EN_RST;
            bod_thr_ff <= crc_pkg::BOD_THR_RST;
        end else if (bod_wr) begin
            bod_en_ff <= pwdata[crc_pkg::EN_BIT];
            bod_thr_ff <= pwdata[crc_pkg::CODE_LSB +: 4];
        end
    end

    // shutdown lock, cleared only by supply loss
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shut_lock_ff <= 1'b0;
        end else if (supply_lost) begin
            shut_lock_ff <= 1'b0;
        end else if (shut_req && !bod_en_ff && !rst_req_ff) begin
            shut_lock_ff <= 1'b1;
        end
    end

    // reset request held until reset arrives
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_req_ff <= 1'b0;
        end else if (shut_req && in_q.core_on_reg && bod_en_ff) begin
            rst_req_ff <= 1'b1;
        end
    end

    assign chip_reset_req = rst_req_ff;

    // ---------------------------------------------
    // Mode and analog controls
    // ---------------------------------------------
    crc_pkg::crc_mode_t mode;
    crc_pkg::crc_ana_out_t nxt_out;
    crc_pkg::crc_ana_out_t out_ff;

    // mode from enable and float bits
    always_comb begin
        if (!en_ff || shut_lock_ff) begin
            mode = crc_pkg::CRC_SHUT;
        end else if (float_ff) begin
            mode = crc_pkg::CRC_FLOAT;
        end else begin
            mode = crc_pkg::CRC_NORMAL;
        end
    end

    // Drive levels per mode
    always_comb begin
        nxt_out = '0;
        nxt_out.level_code = code_ff;
        nxt_out.level_mv = crc_pkg::level_mv(code_ff);
        nxt_out.bod_enable = bod_en_ff;
        nxt_out.bod_threshold = bod_thr_ff;
        case (mode)
            crc_pkg::CRC_NORMAL: begin
                nxt_out.enable = 1'b1;
            end
            crc_pkg::CRC_FLOAT: begin
                nxt_out.float_out = 1'b1;
            end
            crc_pkg::CRC_SHUT: begin
                nxt_out.pull_down = 1'b1;
            end
            default: begin
                nxt_out.pull_down = 1'b1;
            end
        endcase
    end

    // Registered so the analog side sees no glitches
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_ff <= '{enable: 1'b1, float_out: 1'b0, pull_down: 1'b0,
                        level_code: crc_pkg::CODE_RST,
                        level_mv: crc_pkg::MV_RST,
                        bod_enable: crc_pkg::BOD_EN_RST,
                        bod_threshold: crc_pkg::BOD_THR_RST};
        end else begin
            out_ff <= nxt_out;
        end
    end

    assign ana_out = out_ff;

    // ---------------------------------------------
    // Regulation good flag
    // ---------------------------------------------
    logic good_ff;         // Regulation good
    logic [2:0] blank_ff;  // Hold-off after a level raise
    logic raise;
    logic nxt_good;

    // A raise compares voltages, not raw codes
    assign raise = ctrl_wr &&
        (crc_pkg::level_mv(pwdata[crc_pkg::CODE_LSB +: 4]) >
         crc_pkg::level_mv(code_ff));

    // blank covers the comparator sync delay
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blank_ff <= 3'h0;
        end else if (raise) begin
            blank_ff <= crc_pkg::RAISE_BLANK;
        end else if (blank_ff != 3'h0) begin
            blank_ff <= blank_ff - 3'h1;
        end
    end

    always_comb begin
        nxt_good = good_ff;
        if (mode != crc_pkg::CRC_NORMAL || raise || blank_ff != 3'h0) begin
            nxt_good = 1'b0;
        end else if (in_q.current_limit) begin
            nxt_good = 1'b0;
        end else if (good_ff && !in_q.above_deassert) begin
            nxt_good = 1'b0;
        end else if (!good_ff && in_q.above_assert) begin
            nxt_good = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            good_ff <= 1'b0;
        end else begin
            good_ff <= nxt_good;
        end
    end

    // ---------------------------------------------
    // Interrupts
    // ---------------------------------------------
    logic [crc_pkg::N_EV-1:0] ev;
    logic [crc_pkg::N_EV-1:0] stat_ff;  // Sticky events
    logic [crc_pkg::N_EV-1:0] ien_ff;   // Enables
    logic [crc_pkg::N_EV-1:0] clr;
    logic climit_prev_ff;

    // Edge of the limit indication
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            climit_prev_ff <= 1'b0;
        end else begin
            climit_prev_ff <= in_q.current_limit;
        end
    end

    always_comb begin
        ev = '0;
        ev[crc_pkg::EV_GOOD_RISE] = nxt_good & ~good_ff;
        ev[crc_pkg::EV_GOOD_FALL] = ~nxt_good & good_ff;
        ev[crc_pkg::EV_CLIMIT] = in_q.current_limit & ~climit_prev_ff;
        ev[crc_pkg::EV_RST_REQ] = shut_req & in_q.core_on_reg &
                                  bod_en_ff & ~rst_req_ff;
    end

    assign clr = (wr_en && paddr == crc_pkg::ADDR_IRQ_CLR && pstrb[0]) ?
                 pwdata[crc_pkg::N_EV-1:0] : '0;

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_ff <= '0;
        end else begin
            stat_ff <= (stat_ff & ~clr) | ev;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ien_ff <= '0;
        end else if (wr_en && paddr == crc_pkg::ADDR_IRQ_EN && pstrb[0]) begin
            ien_ff <= pwdata[crc_pkg::N_EV-1:0];
        end
    end

    assign irq = |(stat_ff & ien_ff);

    // ---------------------------------------------
    // Read data
    // ---------------------------------------------
    logic [31:0] nxt_rdata;
    logic [31:0] rdata_ff;

    always_comb begin
        nxt_rdata = 32'h0;
        case (paddr)
            crc_pkg::ADDR_CTRL: begin
                nxt_rdata[crc_pkg::EN_BIT] = en_ff & ~shut_lock_ff;
                nxt_rdata[crc_pkg::FLOAT_BIT] = float_ff;
                nxt_rdata[crc_pkg::CODE_LSB +: 4] = code_ff;
                nxt_rdata[crc_pkg::GOOD_BIT] = good_ff;
            end
            crc_pkg::ADDR_BOD: begin
                nxt_rdata[crc_pkg::EN_BIT] = bod_en_ff;
                nxt_rdata[crc_pkg::CODE_LSB +: 4] = bod_thr_ff;
            end
            crc_pkg::ADDR_IRQ_STAT: begin
                nxt_rdata[crc_pkg::N_EV-1:0] = stat_ff;
            end
            crc_pkg::ADDR_IRQ_EN: begin
                nxt_rdata[crc_pkg::N_EV-1:0] = ien_ff;
            end
            default: begin
                nxt_rdata = 32'h0;
            end
        endcase
    end

    // Captured in setup so the access cycle reads a flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 32'h0;
        end else if (setup_ph) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign prdata = rdata_ff;

    // ---------------------------------------------
    // Assertions
    // ---------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    mode_float_a: assert property (
        en_ff && float_ff && !shut_lock_ff |=> ana_out.float_out)
        else $error("Float mode not driven");
    good_float_a: assert property (
        mode == crc_pkg::CRC_FLOAT |=> !good_ff)
        else $error("Good flag high in float mode");
    shut_pull_a: assert property (
        !en_ff |=> ana_out.pull_down && !ana_out.enable)
        else $error("Shutdown output not pulled down");
    lock_hold_a: assert property (
        shut_lock_ff && !supply_lost |=> shut_lock_ff && !ana_out.enable)
        else $error("Shutdown lock released early");
    rst_req_a: assert property (
        shut_req && in_q.core_on_reg && bod_en_ff
        |=> chip_reset_req && en_ff)
        else $error("Reset request missing");
    raise_blank_a: assert property (
        raise |=> !good_ff [*4])
        else $error("Good flag high after raise");
    hyst_fall_a: assert property (
        good_ff && !in_q.above_deassert |=> !good_ff)
        else $error("Good flag missed low threshold");
    climit_a: assert property (
        in_q.current_limit |=> !good_ff)
        else $error("Good flag high in current limit");
    ro_good_a: assert property (
        ctrl_wr && !good_ff && !in_q.above_assert |=> !good_ff)
        else $error("Good flag written by software");
    code_map_a: assert property (
        code_ff <= crc_pkg::CODE_FLOOR
        |=> ana_out.level_mv == crc_pkg::MV_FLOOR)
        else $error("Low codes not at floor voltage");
    irq_level_a: assert property (
        |(stat_ff & ien_ff) |-> irq)
        else $error("Interrupt not raised");

    shut_cov: cover property (shut_req ##1 shut_lock_ff);
    rst_cov: cover property (shut_req ##1 chip_reset_req);
    good_cov: cover property (!good_ff ##1 good_ff ##[1:20] raise);
    irq_cov: cover property ($rose(irq));

endmodule

/* File: bench/crc_ana_model.sv */
// Purpose: Behavioural analog regulator facing crc_regs
// Assumes: Output ramp counted in clk cycles
// Notes: Output level shown as two threshold flags
`timescale 1ns/100ps
module crc_ana_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire crc_pkg::crc_ana_out_t ana_out,
    input wire logic supply_ok,
    input wire logic core_on_reg,
    input wire logic climit,
    output crc_pkg::crc_ana_in_t ana_in
);
    // ------------------------------
    // Output ramp
    // ------------------------------
    logic [3:0] settle_ff; // Cycles since ramp start
    logic [10:0] mv_ff; // Previous target
    logic run; // Powered and driving
    assign run = ana_out.enable & ~ana_out.float_out
        & ~ana_out.pull_down & supply_ok;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_ff <= 4'h0;
            mv_ff <= 11'h000;
        end else begin
            mv_ff <= ana_out.level_mv;
            // Higher target means the output must climb again
            if (!run || ana_out.level_mv > mv_ff) begin
                settle_ff <= 4'h0;
            end else if (settle_ff != 4'hf) begin
                settle_ff <= settle_ff + 4'h1;
            end
        end
    end
    // lower threshold first, limit drops both
    assign ana_in.above_deassert = run & ~climit & (settle_ff > 4'h7);
    assign ana_in.above_assert = run & ~climit & (settle_ff > 4'h9);
    assign ana_in.current_limit = climit;
    assign ana_in.supply_ok = supply_ok;
    assign ana_in.core_on_reg = core_on_reg;
endmodule

/* File: bench/tb.sv */
// Purpose: Self-checking bench for crc_regs
// Assumes: Zero-wait APB slave, 100 MHz clock
// Notes: Each scenario task judges its own results
`timescale 1ns/100ps
module tb;
    // ------------------------------
    // Signals
    // ------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic supply_ok = 1'b1;
    logic core_on_reg = 1'b1;
    logic climit = 1'b0;
    logic chip_reset_req;
    logic irq;
    logic [31:0] rd; // Last read word
    logic err; // Last slave error
    int error_cnt = 0;
    int samples_checked = 0;
    crc_pkg::crc_ana_in_t ana_in;
    crc_pkg::crc_ana_out_t ana_out;

    // Clock, 10 ns period
    always #5 clk = ~clk;

    crc_regs crc_regs_i (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ana_in(ana_in),
        .ana_out(ana_out), .chip_reset_req(chip_reset_req), .irq(irq));
    crc_ana_model crc_ana_model_i (.clk(clk), .rst_n(rst_n),
        .ana_out(ana_out), .supply_ok(supply_ok),
        .core_on_reg(core_on_reg), .climit(climit), .ana_in(ana_in));

    // ------------------------------
    // Helpers
    // ------------------------------
    task automatic chk(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One APB transfer; holds request until pready, idles one cycle
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic t_reset();
        apb(1'b0, crc_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl", rd, 32'h0b1);
        apb(1'b0, crc_pkg::ADDR_BOD, 32'h0);
        chk("bod", rd, 32'h091);
        apb(1'b0, crc_pkg::ADDR_IRQ_EN, 32'h0);
        chk("irq_en", rd, 32'h0);
        chk("mv", 32'(ana_out.level_mv), 32'h44c);
        chk("rst_req", 32'(chip_reset_req), 32'h0);
        $display("test reset done");
    endtask
    task automatic t_level();
        logic [3:0] codes [5] = '{4'h2, 4'h5, 4'h6, 4'hf, 4'hb};
        logic [10:0] mvs [5] = '{11'h320, 11'h320, 11'h352, 11'h514,
            11'h44c};
        cyc(30);
        apb(1'b0, crc_pkg::ADDR_CTRL, 32'h0);
        chk("good", rd, 32'h10b1);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, crc_pkg::ADDR_CTRL, {24'h0, codes[i], 4'h1});
            cyc(2);
            chk("mv", 32'(ana_out.level_mv), 32'(mvs[i]));
        end
        cyc(30);
        apb(1'b1, crc_pkg::ADDR_CTRL, 32'h0c1);
        apb(1'b0, crc_pkg::ADDR_CTRL, 32'h0);
        chk("raise", rd, 32'h0c1);
        cyc(30);
        apb(1'b0, crc_pkg::ADDR_CTRL, 32'h0);
        chk("reached", rd, 32'h10c1);
        $display("test level done");
    endtask
    task automatic t_float();
        apb(1'b1, crc_pkg::ADDR_CTRL, 32'h0c3);
        cyc(6);
        chk("float", 32'(ana_out.float_out), 32'h1);
        chk("pull", 32'(ana_out.pull_down), 32'h0);
        apb(1'b0, crc_pkg::ADDR_CTRL, 32'h0);
        chk("good", rd, 32'h0c3);
        // Read-only flag and reserved bits must not take a write
        apb(1'b1, crc_pkg::ADDR_CTRL, 32'hffff_fff3);
        apb(1'b0, crc_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl rsv", rd, 32'h0f3);
        apb(1'b1, crc_pkg::ADDR_BOD, 32'hffff_ffff);
        apb(1'b0, crc_pkg::ADDR_BOD, 32'h0);
        chk("bod rsv", rd, 32'h0f1);
        apb(1'b1, crc_pkg::ADDR_BOD, 32'h091);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped", {rd[30:0], err}, 32'h1);
        apb(1'b0, crc_pkg::ADDR_RST, 32'h0);
        chk("rst reg", {rd[30:0], err}, 32'h0);
        apb(1'b1, crc_pkg::ADDR_CTRL, 32'h0c1);
        $display("test float done");
    endtask
    task automatic t_irq();
        apb(1'b1, crc_pkg::ADDR_IRQ_EN, 32'h0);
        cyc(30);
        apb(1'b1, crc_pkg::ADDR_IRQ_CLR, 32'hf);
        climit <= 1'b1;
        cyc(10);
        apb(1'b0, crc_pkg::ADDR_IRQ_STAT, 32'h0);
        chk("ev limit", rd & 32'h4, 32'h4);
        apb(1'b0, crc_pkg::ADDR_CTRL, 32'h0);
        chk("limit good", rd, 32'h0c1);
        chk("masked", 32'(irq), 32'h0);
        apb(1'b1, crc_pkg::ADDR_IRQ_EN, 32'h4);
        cyc(1);
        chk("irq on", 32'(irq), 32'h1);
        apb(1'b1, crc_pkg::ADDR_IRQ_CLR, 32'h4);
        cyc(1);
        chk("irq clr", 32'(irq), 32'h0);
        climit <= 1'b0;
        cyc(30);
        apb(1'b0, crc_pkg::ADDR_IRQ_STAT, 32'h0);
        chk("ev rise", rd & 32'h1, 32'h1);
        apb(1'b0, crc_pkg::ADDR_IRQ_CLR, 32'h0);
        chk("clr reads", rd, 32'h0);
        apb(1'b1, crc_pkg::ADDR_IRQ_EN, 32'h0);
        $display("test irq done");
    endtask
    task automatic t_shut_bod();
        apb(1'b1, crc_pkg::ADDR_CTRL, 32'h0c0);
        cyc(2);
        chk("rst_req", 32'(chip_reset_req), 32'h1);
        chk("en kept", 32'(ana_out.enable), 32'h1);
        // Bench plays the chip reset that the request causes
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        cyc(1);
        chk("rst_req", 32'(chip_reset_req), 32'h0);
        apb(1'b0, crc_pkg::ADDR_CTRL, 32'h0);
        chk("normal", rd, 32'h0b1);
        $display("test shutdown reset done");
    endtask
    task automatic t_shut_lock();
        apb(1'b1, crc_pkg::ADDR_BOD, 32'h090);
        apb(1'b1, crc_pkg::ADDR_CTRL, 32'h0b0);
        cyc(2);
        chk("shut en", 32'(ana_out.enable), 32'h0);
        chk("pull", 32'(ana_out.pull_down), 32'h1);
        apb(1'b1, crc_pkg::ADDR_CTRL, 32'h0b1);
        cyc(2);
        chk("locked", 32'(ana_out.enable), 32'h0);
        supply_ok <= 1'b0;
        cyc(8);
        supply_ok <= 1'b1;
        cyc(8);
        chk("restart", 32'(ana_out.enable), 32'h1);
        $display("test shutdown lock done");
    endtask

    // ------------------------------
    // Sequence and watchdog
    // ------------------------------
    initial begin
        cyc(16);
        rst_n <= 1'b1;
        cyc(1);
        t_reset();
        t_level();
        t_float();
        t_irq();
        t_shut_bod();
        t_shut_lock();
        finish_test();
    end
    initial begin
        cyc(50000);
        error_cnt++;
        finish_test();
    end
endmodule
